// *** tcc_capture_compare.sv ***
// Capture, compare, interrupt mask and flag logic of a 16-bit timer.
// What this block does
// - Capture event copies counter into capture register.
// - Capture register can act as counter top.
// - Shared high-byte latch makes 16-bit access atomic.
// - Low byte at base, high byte base plus one.
// - Both compare registers matched against counter on timer ticks.
// - Capture request needs mask bit 5, global flag.
// - Match B request needs mask bit 2, global flag.
// - Match A request needs mask bit 1, global flag.
// - Overflow request needs mask bit 0, global flag.
// - Capture pin event sets capture flag bit 5.
// - Capture-as-top mode sets capture flag at top.
// - Match flags set two cycles after counter equals compare.
// - Forced compare strobes never set match flags.
// - Normal and clear-on-match modes flag overflow.
// - Vector execution clears its interrupt flag.
// - Writing one clears a flag, zero leaves it.
// - Flag register at 0x36 data, 0x16 I/O.
// - Edge select: zero falling, one rising.
// - Capture-as-top mode disconnects the capture pin.
`default_nettype none
module tcc_capture_compare
    import tcc_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire tcc_pkg::tcc_bus_t bus, // Byte-wide register access.
    input wire logic ioSpace, // Access uses the short I/O address space.
    output logic [7:0] readData, // Read data, valid the cycle after rd.
    input wire logic [15:0] counterValue, // Running counter.
    input wire logic timerTick, // Timer clock enable pulse.
    input wire logic counterWritten, // Counter written, blocks next match.
    input wire logic counterOverflow, // Counter wrapped this tick.
    input wire logic [3:0] waveformModeSelect, // Waveform mode.
    input wire logic captureEdgeSelect, // Capture edge select.
    input wire logic captureInputPin, // Capture pin, synchronous.
    input wire logic comparatorOut, // Analog comparator output.
    input wire logic captureFromComparator, // Use comparator as source.
    input wire logic forceMatchAStrobe, // Forced compare on channel A.
    input wire logic forceMatchBStrobe, // Forced compare on channel B.
    input wire logic globalIrqEnable, // Global interrupt flag of the core.
    input wire tcc_pkg::tcc_irq_t vectorTaken, // Vector executed pulses.
    output tcc_pkg::tcc_irq_t irqRequest, // Interrupt requests.
    output logic [15:0] captureValue, // Capture register, also top.
    output logic captureIsTop, // Capture register selected as top.
    output logic matchAEvent, // Channel A match toward waveform logic.
    output logic matchBEvent // Channel B match toward waveform logic.
);
    import tcc_pkg::*;

    function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] base,
                                     input logic high);
        hitAddr = (a == (high ? 8'(base + HIGH_BYTE_STEP) : base));
    endfunction

    logic [7:0] flags_q, flags_d, mask_q, mask_d, temp_q, temp_d, rdata_d;
    logic [15:0] cmpA_q, cmpA_d, cmpB_q, cmpB_d, cap_q, cap_d;
    logic block_q, block_d, mA_q, mA_d, mB_q, mB_d;
    logic src_q, src_d;
    tcc_irq_t irq_d;
    tcc_latch_state_t lst_q, lst_d;
    logic [7:0] addr, setv, clrv;
    logic icrTop, src, capEvent, eqA, eqB, flagAcc;

    always_comb begin
        // I/O-space addresses are the data address minus the fixed offset;
        // only the flag register lives below the extended area.
        addr = bus.addr;
        if (ioSpace) begin
            addr = 8'(bus.addr + IO_SPACE_OFFSET);
        end
        // Extended registers answer only to data-space accesses.
        flagAcc = hitAddr(addr, ADDR_IRQ_FLAGS, 1'b0);
        if (ioSpace && addr >= EXT_IO_BASE) begin
            addr = 8'h00;
        end
        icrTop = (waveformModeSelect == WGM_PFC_ICR) || (waveformModeSelect == WGM_PC_ICR)
            || (waveformModeSelect == WGM_CTC_ICR) || (waveformModeSelect == WGM_FAST_ICR);
        src = captureFromComparator ? comparatorOut : captureInputPin;
        src_d = src;
        // Edge on the selected source; the pin is ignored when it is the top.
        capEvent = !icrTop && (captureEdgeSelect ? (src && !src_q)
                                                  : (!src && src_q));
        eqA = timerTick && !block_q && (counterValue == cmpA_q);
        eqB = timerTick && !block_q && (counterValue == cmpB_q);
        block_d = counterWritten ? 1'b1 : (timerTick ? 1'b0 : block_q);
        mA_d = eqA;
        mB_d = eqB;
        // Set sources; force strobes deliberately play no part here.
        setv = REG8_RESET;
        setv[BIT_MATCH_A] = mA_q;
        setv[BIT_MATCH_B] = mB_q;
        setv[BIT_CAPTURE] = capEvent
            || (icrTop && timerTick && counterValue == cap_q);
        setv[BIT_OVF] = counterOverflow && ((waveformModeSelect == WGM_NORMAL)
            || (waveformModeSelect == WGM_CTC_A) || (waveformModeSelect == WGM_CTC_ICR));
        clrv = REG8_RESET;
        clrv[BIT_OVF] = vectorTaken.overflow;
        clrv[BIT_MATCH_A] = vectorTaken.matchA;
        clrv[BIT_MATCH_B] = vectorTaken.matchB;
        clrv[BIT_CAPTURE] = vectorTaken.capture;
        if (bus.wr && flagAcc) begin
            clrv = clrv | bus.wdata;
        end
        flags_d = ((flags_q & ~clrv) | setv) & FLAG_MASK;

        mask_d = mask_q;
        cmpA_d = cmpA_q;
        cmpB_d = cmpB_q;
        cap_d = capEvent ? counterValue : cap_q;
        temp_d = temp_q;
        lst_d = lst_q;
        rdata_d = REG8_RESET;
        if (bus.wr) begin
            if (hitAddr(addr, ADDR_IRQ_MASK, 1'b0)) begin
                mask_d = bus.wdata & FLAG_MASK;
            end
            // High byte goes to the shared latch; the low write commits both.
            if (hitAddr(addr, ADDR_CMP_A, 1'b1) || hitAddr(addr, ADDR_CMP_B, 1'b1)
                || hitAddr(addr, ADDR_CAPTURE, 1'b1)) begin
                temp_d = bus.wdata;
                lst_d = TCC_HIGH_HELD;
            end
            if (hitAddr(addr, ADDR_CMP_A, 1'b0)) begin
                cmpA_d = {temp_q, bus.wdata};
                lst_d = TCC_IDLE;
            end
            if (hitAddr(addr, ADDR_CMP_B, 1'b0)) begin
                cmpB_d = {temp_q, bus.wdata};
                lst_d = TCC_IDLE;
            end
            // A capture event in the same cycle wins over a software write of the low byte.
            if (hitAddr(addr, ADDR_CAPTURE, 1'b0) && !capEvent) begin
                cap_d = {temp_q, bus.wdata};
                lst_d = TCC_IDLE;
            end
        end else if (bus.rd) begin
            case (1'b1)
                flagAcc: rdata_d = flags_q;
                hitAddr(addr, ADDR_IRQ_MASK, 1'b0): rdata_d = mask_q;
                hitAddr(addr, ADDR_CMP_A, 1'b0): rdata_d = cmpA_q[7:0];
                hitAddr(addr, ADDR_CMP_A, 1'b1): rdata_d = cmpA_q[15:8];
                hitAddr(addr, ADDR_CMP_B, 1'b0): rdata_d = cmpB_q[7:0];
                hitAddr(addr, ADDR_CMP_B, 1'b1): rdata_d = cmpB_q[15:8];
                hitAddr(addr, ADDR_CAPTURE, 1'b0): begin
                    // Low read snapshots the high byte for the next read.
                    rdata_d = cap_q[7:0];
                    temp_d = cap_q[15:8];
                    lst_d = TCC_HIGH_HELD;
                end
                hitAddr(addr, ADDR_CAPTURE, 1'b1): begin
                    rdata_d = temp_q;
                    lst_d = TCC_IDLE;
                end
                default: rdata_d = REG8_RESET;
            endcase
        end
        irq_d.capture = flags_q[BIT_CAPTURE] && mask_q[BIT_CAPTURE] && globalIrqEnable;
        irq_d.matchB = flags_q[BIT_MATCH_B] && mask_q[BIT_MATCH_B] && globalIrqEnable;
        irq_d.matchA = flags_q[BIT_MATCH_A] && mask_q[BIT_MATCH_A] && globalIrqEnable;
        irq_d.overflow = flags_q[BIT_OVF] && mask_q[BIT_OVF] && globalIrqEnable;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= REG8_RESET;
            mask_q <= REG8_RESET;
            temp_q <= REG8_RESET;
            readData <= REG8_RESET;
            cmpA_q <= REG16_RESET;
            cmpB_q <= REG16_RESET;
            cap_q <= REG16_RESET;
            captureValue <= REG16_RESET;
            captureIsTop <= 1'b0;
            src_q <= 1'b0;
            block_q <= 1'b0;
            mA_q <= 1'b0;
            mB_q <= 1'b0;
            matchAEvent <= 1'b0;
            matchBEvent <= 1'b0;
            irqRequest <= '0;
            lst_q <= TCC_IDLE;
        end else begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            temp_q <= temp_d;
            readData <= rdata_d;
            cmpA_q <= cmpA_d;
            cmpB_q <= cmpB_d;
            cap_q <= cap_d;
            captureValue <= cap_d;
            captureIsTop <= icrTop;
            src_q <= src_d;
            block_q <= block_d;
            mA_q <= mA_d;
            mB_q <= mB_d;
            matchAEvent <= eqA || forceMatchAStrobe;
            matchBEvent <= eqB || forceMatchBStrobe;
            irqRequest <= irq_d;
            lst_q <= lst_d;
        end
    end
endmodule
`default_nettype wire

// *** tcc_capture_compare_props.sv ***
// Port assertions for the capture/compare block.
`default_nettype none
module tcc_capture_compare_props
    import tcc_pkg::*;
(
    input wire logic clock, // Clock.
    input wire logic rst_n, // Reset.
    input wire tcc_pkg::tcc_bus_t bus, // Bus.
    input wire logic ioSpace, // Short form.
    input wire logic [7:0] readData, // Read data.
    input wire logic timerTick, // Tick.
    input wire logic forceMatchAStrobe, // Force A.
    input wire logic forceMatchBStrobe, // Force B.
    input wire logic globalIrqEnable, // Global enable.
    input wire logic [3:0] waveformModeSelect, // Mode.
    input wire tcc_pkg::tcc_irq_t irqRequest, // Requests.
    input wire logic captureIsTop, // Capture is top.
    input wire logic matchAEvent, // Match A.
    input wire logic matchBEvent // Match B.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    chk_gate_cap: assert property (!globalIrqEnable |=> !irqRequest.capture)
        else $error("capture request while disabled");
    chk_gate_b: assert property (!globalIrqEnable |=> !irqRequest.matchB)
        else $error("match B request while disabled");
    chk_gate_a: assert property (!globalIrqEnable |=> !irqRequest.matchA)
        else $error("match A request while disabled");
    chk_gate_ovf: assert property (!globalIrqEnable |=> !irqRequest.overflow)
        else $error("overflow request while disabled");
    chk_ext_refused: assert property (bus.rd && ioSpace && bus.addr >= 8'h40 |=> readData == 8'h00)
        else $error("short form reached extended space");
    chk_top_mode: assert property (captureIsTop ==
        ($past(waveformModeSelect[3]) && !$past(waveformModeSelect[0])))
        else $error("capture-as-top flag wrong");
    chk_match_a_cause: assert property (matchAEvent |-> $past(timerTick || forceMatchAStrobe))
        else $error("match A without tick");
    chk_match_b_cause: assert property (matchBEvent |-> $past(timerTick || forceMatchBStrobe))
        else $error("match B without tick");
endmodule
`default_nettype wire

// *** tcc_capture_compare_tb.sv ***
// Self-checking bench for the capture/compare block.
`default_nettype none
module tcc_capture_compare_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, tick = 1'b0, ovf = 1'b0, pin = 1'b0, gie = 1'b0;
    logic edgeSel = 1'b1, fa = 1'b0, fb = 1'b0, io, isTop, evA, evB;
    logic [15:0] cv = 16'h0000, capV;
    logic [7:0] rdData, q;
    logic [3:0] mode = 4'h0;
    tcc_irq_t vt = '0, irq;
    tcc_bus_t bus;
    int fails = 0, n_checks = 0, cyc = 0;
    tcc_cpu_model u_cpu(.clock(clock), .readData(rdData), .bus(bus), .ioSpace(io));
    tcc_capture_compare u_dut(.clock(clock), .rst_n(rst_n), .bus(bus), .ioSpace(io),
        .readData(rdData), .counterValue(cv), .timerTick(tick), .counterWritten(1'b0),
        .counterOverflow(ovf), .waveformModeSelect(mode), .captureEdgeSelect(edgeSel),
        .captureInputPin(pin), .comparatorOut(1'b0), .captureFromComparator(1'b0),
        .forceMatchAStrobe(fa), .forceMatchBStrobe(fb), .globalIrqEnable(gie),
        .vectorTaken(vt), .irqRequest(irq), .captureValue(capV), .captureIsTop(isTop),
        .matchAEvent(evA), .matchBEvent(evB));
    initial forever #25 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) fails++;
        if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    endtask
    // On a read, d is the expected byte.
    task automatic rw(input logic w, input logic [7:0] a, d, input logic i = 1'b0);
        u_cpu.access(w, a, d, i, q);
        if (!w) chk(q, d);
    endtask
    task automatic ev(input logic [15:0] c, input logic t, o, p);
        @(negedge clock);
        {cv, tick, ovf, pin} = {c, t, o, p};
        @(negedge clock);
        {tick, ovf} = 2'b00;
        repeat (2) @(negedge clock);
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        rw(1'b0, ADDR_IRQ_MASK, 8'h00);
        rw(1'b0, ADDR_IRQ_FLAGS, 8'h00);
        rw(1'b1, ADDR_CMP_A + 8'h01, 8'h12);
        rw(1'b1, ADDR_CMP_A, 8'h34);
        rw(1'b1, ADDR_CMP_B + 8'h01, 8'h56);
        rw(1'b1, ADDR_CMP_B, 8'h78);
        rw(1'b0, ADDR_CMP_A + 8'h01, 8'h12);
        rw(1'b0, ADDR_CMP_B, 8'h78);
        rw(1'b1, ADDR_IRQ_MASK, 8'hFF);
        ev(16'h1234, 1'b1, 1'b0, 1'b0);
        ev(16'h5678, 1'b1, 1'b1, 1'b0);
        ev(16'hABCD, 1'b0, 1'b0, 1'b1);
        ev(16'h1111, 1'b0, 1'b0, 1'b0);
        rw(1'b0, ADDR_CAPTURE, 8'hCD);
        rw(1'b0, ADDR_CAPTURE + 8'h01, 8'hAB);
        chk(capV[7:0], 8'hCD);
        chk(capV[15:8], 8'hAB);
        rw(1'b0, ADDR_IRQ_FLAGS, 8'h27);
        gie = 1'b1;
        rw(1'b0, ADDR_IRQ_MASK, FLAG_MASK);
        chk({4'h0, irq}, 8'h0F);
        rw(1'b1, ADDR_IRQ_FLAGS, 8'h02);
        rw(1'b1, ADDR_IRQ_FLAGS - IO_SPACE_OFFSET, 8'h01, 1'b1);
        vt.capture = 1'b1;
        @(negedge clock) vt = '0;
        rw(1'b0, ADDR_IRQ_FLAGS - IO_SPACE_OFFSET, 8'h04, 1'b1);
        {cv, tick} = {16'h5678, 1'b1};
        fork
            rw(1'b1, ADDR_IRQ_FLAGS, 8'h04);
            @(negedge clock) tick = 1'b0;
        join
        rw(1'b0, ADDR_IRQ_FLAGS, 8'h04);
        gie = 1'b0;
        rw(1'b1, ADDR_IRQ_FLAGS, 8'hFF);
        {fa, fb} = 2'b11;
        @(negedge clock) {fa, fb} = 2'b00;
        chk({6'h00, evA, evB}, 8'h03);
        rw(1'b0, ADDR_IRQ_FLAGS, 8'h00);
        rw(1'b1, ADDR_IRQ_MASK - IO_SPACE_OFFSET, 8'h00, 1'b1);
        rw(1'b0, ADDR_IRQ_MASK, FLAG_MASK);
        rw(1'b0, ADDR_IRQ_MASK - IO_SPACE_OFFSET, 8'h00, 1'b1);
        {mode, edgeSel} = {WGM_CTC_ICR, 1'b0};
        ev(16'h2222, 1'b0, 1'b0, 1'b1);
        ev(16'h3333, 1'b0, 1'b0, 1'b0);
        rw(1'b0, ADDR_CAPTURE, 8'hCD);
        chk({7'h00, isTop}, 8'h01);
        ev(16'hABCD, 1'b1, 1'b0, 1'b0);
        rw(1'b0, ADDR_IRQ_FLAGS, 8'h20);
        close_out();
    end
endmodule
bind tcc_capture_compare tcc_capture_compare_props u_props(.clock(clock), .rst_n(rst_n),
    .bus(bus), .ioSpace(ioSpace), .readData(readData), .timerTick(timerTick),
    .forceMatchAStrobe(forceMatchAStrobe), .forceMatchBStrobe(forceMatchBStrobe),
    .globalIrqEnable(globalIrqEnable), .waveformModeSelect(waveformModeSelect),
    .irqRequest(irqRequest), .captureIsTop(captureIsTop), .matchAEvent(matchAEvent),
    .matchBEvent(matchBEvent));
`default_nettype wire

// *** tcc_cpu_model.sv ***
// Core side model: byte accesses on the internal register bus.
`default_nettype none
module tcc_cpu_model
    import tcc_pkg::*;
(
    input wire logic clock, // Clock.
    input wire logic [7:0] readData, // Read data.
    output tcc_pkg::tcc_bus_t bus, // Bus.
    output logic ioSpace // Short form.
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {bus, ioSpace} = '0;
    // High byte goes first on 16-bit writes; short form is passed on even into extended space.
    task automatic access(input logic w, input logic [7:0] a, d, input logic i,
                          output logic [7:0] q);
        @(negedge clock);
        {bus, ioSpace} = {w, !w, a, d, i};
        @(negedge clock);
        // Read data stands for one cycle only, so it is taken before release.
        q = readData;
        // Released lines carry the inverse so a stale value is never taken as live.
        {bus, ioSpace} = {2'b00, ~a, ~d, !i};
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

// *** tcc_pkg.sv ***
// Package for the timer capture/compare and interrupt flag block.
`default_nettype none
package tcc_pkg;
    // Data-space byte addresses of the registers.
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h36;
    localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h6F;
    localparam logic [7:0] ADDR_CAPTURE = 8'h86;
    localparam logic [7:0] ADDR_CMP_A = 8'h88;
    localparam logic [7:0] ADDR_CMP_B = 8'h8A;
    localparam logic [7:0] HIGH_BYTE_STEP = 8'h01;
    localparam logic [7:0] EXT_IO_BASE = 8'h60;
    // Flag and mask bit positions.
    localparam int BIT_OVF = 0;
    localparam int BIT_MATCH_A = 1;
    localparam int BIT_MATCH_B = 2;
    localparam int BIT_CAPTURE = 5;
    localparam logic [7:0] FLAG_MASK = 8'h27;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // Waveform modes that matter here.
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_A = 4'h4;
    localparam logic [3:0] WGM_PFC_ICR = 4'h8;
    localparam logic [3:0] WGM_PC_ICR = 4'hA;
    localparam logic [3:0] WGM_CTC_ICR = 4'hC;
    localparam logic [3:0] WGM_FAST_ICR = 4'hE;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcc_bus_t;

    typedef struct packed {
        logic capture;
        logic matchB;
        logic matchA;
        logic overflow;
    } tcc_irq_t;

    typedef enum logic [1:0] {
        TCC_IDLE = 2'b00,
        TCC_HIGH_HELD = 2'b01
    } tcc_latch_state_t;
endpackage
`default_nettype wire
